// ### logic/rdsc_pkg.sv
// Package with command codes, field layouts, reset values and types.
package rdsc_pkg;
    localparam logic [7:0] CMD_TEMPCO = 8'hDC;
    localparam logic [7:0] CMD_DT_VALUES = 8'hDD;
    localparam logic [7:0] CMD_DT_MODE = 8'hDE;
    localparam logic [7:0] CMD_ORDER = 8'hE0;
    localparam logic [7:0] CMD_FOLLOW = 8'hE1;
    localparam logic [7:0] CMD_LISTEN = 8'hE2;
    localparam logic [7:0] RST_TEMPCO = 8'h2C;
    localparam logic [15:0] RST_DT_VALUES = 16'h1018;
    localparam logic [15:0] RST_DT_MODE = 16'h8686;
    localparam logic [15:0] RST_ORDER = 16'h0000;
    localparam logic [7:0] RST_FOLLOW = 8'h00;
    localparam logic [31:0] RST_LISTEN = 32'h00000000;
    localparam logic [15:0] ORDER_USED_MASK = 16'h9F9F;
    localparam logic [7:0] FOLLOW_USED_MASK = 8'h87;
    localparam int TC_SRC_BIT = 7;
    localparam int DT_HL_FRZ_BIT = 15;
    localparam int DT_LH_FRZ_BIT = 7;
    localparam int ORD_PRE_EN_BIT = 15;
    localparam int ORD_SEQ_EN_BIT = 7;
    localparam int TRK_EN_BIT = 7;
    localparam int TRK_HALF_BIT = 2;
    localparam int TRK_LIM_BIT = 1;
    localparam int TRK_ALWAYS_BIT = 0;
    localparam logic signed [8:0] T_REF_DEGC = 9'sh019;
    localparam int TC_SCALE = 10000;
    typedef enum logic [1:0] {
        EVT_PWR_GOOD,
        EVT_PWR_DOWN,
        EVT_FAULT,
        EVT_CLEAR
    } rdsc_evt_kind_t;
    typedef struct packed {
        logic valid;
        rdsc_evt_kind_t kind;
        logic [4:0] rail_identifier;
    } rdsc_evt_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [31:0] wdata;
    } rdsc_cmd_t;
    typedef struct packed {
        logic valid;
        logic unsupported;
        logic [31:0] rdata;
    } rdsc_rsp_t;
    typedef struct packed {
        logic enable;
        logic half_ratio;
        logic limit_by_input;
        logic allow_down;
    } rdsc_track_t;
endpackage : rdsc_pkg

// ### logic/rdsc_rail_config.sv
// Rail configuration bank with dead time, sequencing, tracking and faults.
// Function
// - Temperature source bit clear selects the internal sensor for correction.
// - Correction factor in 100 ppm per degree corrects a positive tempco.
// - Sense resistance equals gain times one plus factor times temperature minus 25.
// - Upper dead-time byte is high-to-low, lower byte low-to-high, signed ns.
// - Positive dead time means non-overlap, negative means overlap.
// - Frozen dead time uses written values clamped between minimum and maximum.
// - Changing adaptive to frozen keeps the last dead time in use.
// - Bit 15 freezes high-to-low, bit 7 freezes low-to-high dead time.
// - Adaptive dead time stays at or above the 2 ns step minimum unless nonoverlap_upper_bound is lower.
// - Prequel enabled: turn on after enable and prequel power-good event.
// - Sequel enabled: turn off with delay after sequel power-down event.
// - Sequencing word holds prequel and sequel enables and rail identifiers.
// - A written sequencing word overrides the strapped sequencing setting.
// - Bit 7 enables tracking, bit 2 picks full or half ratio.
// - Bit 1 caps output at target or at tracking input voltage.
// - Bit 0 clear blocks following a falling input before power good.
// - Fault-listen word is a mask of rail identifiers whose faults count; the rail's own identifier bit is ignored.
// - A shared rail reports shutdown only when all its devices are down.
// - Spreading on: shut down at once, restart when all listened faults clear.
// - Spreading off: sequenced shutdown, restart after listened faults clear.
// - Spreading and sequencing off: ignore other rails' faults, stay enabled.
// - Each rail holds a five bit identifier used on the inter-rail bus.
`timescale 1ns/1ns
module rdsc_rail_config #(
    parameter int OFF_DLY_W = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire rdsc_pkg::rdsc_cmd_t cmd,
    output rdsc_pkg::rdsc_rsp_t rsp,
    input wire logic [15:0] strap_order,
    input wire logic [4:0] strap_rail_identifier,
    input wire logic [7:0] internal_temp,
    input wire logic [7:0] external_temp,
    input wire logic [15:0] current_sense_gain,
    output logic signed [31:0] sense_element_resistance,
    input wire logic signed [7:0] adapt_hl_ns,
    input wire logic signed [7:0] adapt_lh_ns,
    input wire logic signed [7:0] nonoverlap_upper_bound,
    output logic signed [9:0] hl_fet_nonoverlap_values_ns,
    output logic signed [9:0] lh_fet_nonoverlap_values_ns,
    input wire logic enable_request,
    input wire logic power_good_flag,
    input wire logic fault_spread_en,
    input wire logic share_all_down,
    input wire logic [OFF_DLY_W-1:0] off_delay_cycles,
    input wire rdsc_pkg::rdsc_evt_t inter_rail_bus_rx,
    output rdsc_pkg::rdsc_evt_t inter_rail_bus_tx,
    output logic rail_output_on,
    output logic rail_shutdown_report,
    output rdsc_pkg::rdsc_track_t track_ctrl
);
    import rdsc_pkg::*;

    typedef enum logic [2:0] {
        RS_OFF,
        RS_ON,
        RS_OFF_DELAY,
        RS_FAULT_HOLD
    } rdsc_state_t;

    logic [7:0] tempco_q;
    logic [15:0] dt_values_q;
    logic [15:0] dt_mode_q;
    logic [15:0] order_q;
    logic order_written_q;
    logic [7:0] follow_q;
    logic [31:0] listen_q;
    logic [15:0] strap_order_m_q, strap_order_s_q, strap_order_cap_q;
    logic [4:0] strap_id_m_q, strap_id_s_q, own_id_q;
    logic strap_cap_done_q;
    logic [1:0] strap_fill_q;
    logic signed [8:0] temp_sel;
    logic signed [9:0] dtemp;
    logic signed [17:0] tc_dt;
    logic signed [35:0] corr;
    logic signed [9:0] frz_hl_q, frz_lh_q;
    logic [31:0] faulted_q;
    logic pre_seen_q;
    logic pg_prev_q;
    logic [OFF_DLY_W-1:0] dly_cnt_q;
    rdsc_state_t state_q;

    logic wr;
    logic [15:0] order_eff;
    logic [31:0] listen_eff;
    logic listen_fault_any;
    logic seq_down_evt;
    logic pre_en, seq_en;

    function automatic logic signed [9:0] dt_clamp(
        input logic signed [9:0] v,
        input logic [6:0] min_steps,
        input logic signed [7:0] max_ns
    );
        logic signed [9:0] lo;
        logic signed [9:0] hi;
        lo = $signed({2'b00, min_steps, 1'b0});
        hi = 10'(max_ns);
        if (v < lo) begin
            dt_clamp = lo;
        end else if (v > hi) begin
            dt_clamp = hi;
        end else begin
            dt_clamp = v;
        end
    endfunction : dt_clamp

    function automatic logic evt_from(
        input rdsc_evt_t e,
        input rdsc_evt_kind_t k,
        input logic [4:0] id
    );
        evt_from = e.valid && e.kind == k && e.rail_identifier == id;
    endfunction : evt_from

    assign wr = ce && cmd.valid && cmd.write;

    // Command port: writes store, reads answer one cycle later.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tempco_q <= RST_TEMPCO;
            dt_values_q <= RST_DT_VALUES;
            dt_mode_q <= RST_DT_MODE;
            order_q <= RST_ORDER;
            order_written_q <= 1'b0;
            follow_q <= RST_FOLLOW;
            listen_q <= RST_LISTEN;
        end else if (wr) begin
            case (cmd.code)
                CMD_TEMPCO: tempco_q <= cmd.wdata[7:0];
                CMD_DT_VALUES: dt_values_q <= cmd.wdata[15:0];
                CMD_DT_MODE: dt_mode_q <= cmd.wdata[15:0];
                CMD_ORDER: begin
                    order_q <= cmd.wdata[15:0] & ORDER_USED_MASK;
                    order_written_q <= 1'b1;
                end
                CMD_FOLLOW: follow_q <= cmd.wdata[7:0] & FOLLOW_USED_MASK;
                CMD_LISTEN: listen_q <= cmd.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rsp <= '0;
        end else if (ce) begin
            rsp.valid <= cmd.valid;
            rsp.unsupported <= 1'b0;
            rsp.rdata <= '0;
            if (cmd.valid) begin
                case (cmd.code)
                    CMD_TEMPCO: rsp.rdata <= {24'h000000, tempco_q};
                    CMD_DT_VALUES: rsp.rdata <= {16'h0000, dt_values_q};
                    CMD_DT_MODE: rsp.rdata <= {16'h0000, dt_mode_q};
                    CMD_ORDER: rsp.rdata <= {16'h0000, order_eff};
                    CMD_FOLLOW: rsp.rdata <= {24'h000000, follow_q};
                    CMD_LISTEN: rsp.rdata <= listen_q;
                    default: rsp.unsupported <= 1'b1;
                endcase
            end
        end
    end

    // Strap pins pass two flops and are captured once both flops hold pins.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strap_order_m_q <= 16'h0000;
            strap_order_s_q <= 16'h0000;
            strap_id_m_q <= 5'h00;
            strap_id_s_q <= 5'h00;
            strap_fill_q <= 2'b00;
        end else if (ce) begin
            strap_order_m_q <= strap_order;
            strap_order_s_q <= strap_order_m_q;
            strap_id_m_q <= strap_rail_identifier;
            strap_id_s_q <= strap_id_m_q;
            strap_fill_q <= {strap_fill_q[0], 1'b1};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strap_order_cap_q <= 16'h0000;
            own_id_q <= 5'h00;
            strap_cap_done_q <= 1'b0;
        end else if (ce && strap_fill_q[1] && !strap_cap_done_q) begin
            strap_order_cap_q <= strap_order_s_q & ORDER_USED_MASK;
            own_id_q <= strap_id_s_q;
            strap_cap_done_q <= 1'b1;
        end
    end

    assign order_eff = order_written_q ? order_q : strap_order_cap_q;
    assign pre_en = order_eff[ORD_PRE_EN_BIT];
    assign seq_en = order_eff[ORD_SEQ_EN_BIT];
    assign listen_eff = listen_q & ~(32'h00000001 << own_id_q);
    assign listen_fault_any = |(faulted_q & listen_eff);
    assign seq_down_evt = evt_from(inter_rail_bus_rx, EVT_PWR_DOWN,
        order_eff[4:0]);

    // Sense element resistance from the chosen temperature source.
    assign temp_sel = tempco_q[TC_SRC_BIT] ? 9'(signed'(external_temp))
        : 9'(signed'(internal_temp));
    assign dtemp = 10'(temp_sel) - 10'(T_REF_DEGC);
    assign tc_dt = $signed({11'h000, tempco_q[6:0]}) * 18'(dtemp);
    assign corr = $signed({20'h00000, current_sense_gain}) * 36'(tc_dt);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sense_element_resistance <= 32'sh00000000;
        end else if (ce) begin
            sense_element_resistance <= 32'(
                $signed({20'h00000, current_sense_gain})
                + corr / 36'(TC_SCALE));
        end
    end

    // Dead time: adaptive follows the loop, frozen holds its own value.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frz_hl_q <= 10'(signed'(RST_DT_VALUES[15:8]));
            frz_lh_q <= 10'(signed'(RST_DT_VALUES[7:0]));
        end else if (wr && cmd.code == CMD_DT_VALUES) begin
            frz_hl_q <= 10'(signed'(cmd.wdata[15:8]));
            frz_lh_q <= 10'(signed'(cmd.wdata[7:0]));
        end else if (wr && cmd.code == CMD_DT_MODE) begin
            if (!dt_mode_q[DT_HL_FRZ_BIT] && cmd.wdata[DT_HL_FRZ_BIT]) begin
                frz_hl_q <= hl_fet_nonoverlap_values_ns;
            end
            if (!dt_mode_q[DT_LH_FRZ_BIT] && cmd.wdata[DT_LH_FRZ_BIT]) begin
                frz_lh_q <= lh_fet_nonoverlap_values_ns;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hl_fet_nonoverlap_values_ns <= 10'(signed'(RST_DT_VALUES[15:8]));
            lh_fet_nonoverlap_values_ns <= 10'(signed'(RST_DT_VALUES[7:0]));
        end else if (ce) begin
            hl_fet_nonoverlap_values_ns <= dt_clamp(dt_mode_q[DT_HL_FRZ_BIT] ? frz_hl_q
                : 10'(adapt_hl_ns), dt_mode_q[14:8],
                nonoverlap_upper_bound);
            lh_fet_nonoverlap_values_ns <= dt_clamp(dt_mode_q[DT_LH_FRZ_BIT] ? frz_lh_q
                : 10'(adapt_lh_ns), dt_mode_q[6:0],
                nonoverlap_upper_bound);
        end
    end

    // Fault set per rail and prequel power-good memory; set wins over clear.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            faulted_q <= 32'h00000000;
            pre_seen_q <= 1'b0;
        end else if (ce && inter_rail_bus_rx.valid) begin
            if (inter_rail_bus_rx.kind == EVT_FAULT) begin
                faulted_q[inter_rail_bus_rx.rail_identifier] <= 1'b1;
            end else if (inter_rail_bus_rx.kind == EVT_CLEAR) begin
                faulted_q[inter_rail_bus_rx.rail_identifier] <= 1'b0;
            end
            if (evt_from(inter_rail_bus_rx, EVT_PWR_GOOD, order_eff[12:8])) begin
                pre_seen_q <= 1'b1;
            end else if (evt_from(inter_rail_bus_rx, EVT_PWR_DOWN,
                order_eff[12:8])) begin
                pre_seen_q <= 1'b0;
            end
        end
    end

    // Output sequencing and fault reaction.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= RS_OFF;
            dly_cnt_q <= '0;
        end else if (ce) begin
            case (state_q)
                RS_OFF: begin
                    if (enable_request && (!pre_en || pre_seen_q)) begin
                        state_q <= RS_ON;
                    end
                end
                RS_ON: begin
                    dly_cnt_q <= '0;
                    if (fault_spread_en && listen_fault_any) begin
                        state_q <= RS_FAULT_HOLD;
                    end else if (!fault_spread_en && (pre_en || seq_en)
                        && listen_fault_any) begin
                        state_q <= RS_OFF_DELAY;
                    end else if (seq_en && seq_down_evt) begin
                        state_q <= RS_OFF_DELAY;
                    end else if (!enable_request) begin
                        state_q <= RS_OFF_DELAY;
                    end
                end
                RS_OFF_DELAY: begin
                    if (fault_spread_en && listen_fault_any) begin
                        state_q <= RS_FAULT_HOLD;
                    end else if (dly_cnt_q >= off_delay_cycles) begin
                        state_q <= listen_fault_any ? RS_FAULT_HOLD
                            : RS_OFF;
                    end else begin
                        dly_cnt_q <= dly_cnt_q + 1'b1;
                    end
                end
                RS_FAULT_HOLD: begin
                    if (!listen_fault_any) begin
                        state_q <= RS_OFF;
                    end
                end
                default: state_q <= RS_OFF;
            endcase
        end
    end

    // Registered outputs and events sent to peer rails.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rail_output_on <= 1'b0;
            rail_shutdown_report <= 1'b0;
            pg_prev_q <= 1'b0;
            inter_rail_bus_tx <= '0;
        end else if (ce) begin
            rail_output_on <= state_q == RS_ON || state_q == RS_OFF_DELAY;
            rail_shutdown_report <= share_all_down
                && !(state_q == RS_ON || state_q == RS_OFF_DELAY);
            pg_prev_q <= power_good_flag;
            inter_rail_bus_tx <= '0;
            inter_rail_bus_tx.rail_identifier <= own_id_q;
            if (power_good_flag && !pg_prev_q && rail_output_on) begin
                inter_rail_bus_tx.valid <= 1'b1;
                inter_rail_bus_tx.kind <= EVT_PWR_GOOD;
            end else if (rail_output_on && (state_q == RS_OFF
                || state_q == RS_FAULT_HOLD)) begin
                inter_rail_bus_tx.valid <= 1'b1;
                inter_rail_bus_tx.kind <= EVT_PWR_DOWN;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            track_ctrl <= '0;
        end else if (ce) begin
            track_ctrl.enable <= follow_q[TRK_EN_BIT];
            track_ctrl.half_ratio <= follow_q[TRK_HALF_BIT];
            track_ctrl.limit_by_input <= follow_q[TRK_LIM_BIT];
            track_ctrl.allow_down <= follow_q[TRK_ALWAYS_BIT]
                || power_good_flag;
        end
    end

    sequence spread_fault_s;
        ce && state_q == RS_ON && fault_spread_en && listen_fault_any;
    endsequence

    sequence off_seen_s;
        !rail_output_on;
    endsequence

    spread_off_a: assert property (@(posedge core_clk) disable iff (rst)
        spread_fault_s ##1 ce |=> off_seen_s)
        else $error("Spread fault did not drop output.");

    hold_restart_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == RS_FAULT_HOLD && listen_fault_any
        |=> state_q == RS_FAULT_HOLD)
        else $error("Restart while listened fault present.");

    ignore_fault_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && state_q == RS_ON && !fault_spread_en && !pre_en && !seq_en
        && enable_request |=> state_q == RS_ON)
        else $error("Rail left on state despite ignoring faults.");

    prequel_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == RS_OFF && pre_en && !pre_seen_q |=> state_q != RS_ON)
        else $error("Turned on before prequel power good.");

    dt_min_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && !dt_mode_q[DT_HL_FRZ_BIT] && $stable(dt_mode_q) |=>
        hl_fet_nonoverlap_values_ns >= $signed({2'b00, $past(dt_mode_q[14:8]), 1'b0})
        || hl_fet_nonoverlap_values_ns == 10'($past(nonoverlap_upper_bound)))
        else $error("High-to-low dead time below minimum.");

    freeze_keep_a: assert property (@(posedge core_clk) disable iff (rst)
        wr && cmd.code == CMD_DT_MODE && !dt_mode_q[DT_HL_FRZ_BIT]
        && cmd.wdata[DT_HL_FRZ_BIT] |=> frz_hl_q == $past(hl_fet_nonoverlap_values_ns))
        else $error("Frozen dead time not last value in use.");

    order_override_a: assert property (@(posedge core_clk) disable iff (rst)
        wr && cmd.code == CMD_ORDER |=> order_eff
        == ($past(cmd.wdata[15:0]) & ORDER_USED_MASK))
        else $error("Strap setting overrode written sequencing word.");

    reserved_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        rsp.valid && !rsp.unsupported |-> (rsp.rdata[15:0]
        & ~ORDER_USED_MASK) == 16'h0000 || $past(cmd.code) != CMD_ORDER)
        else $error("Reserved sequencing bits read nonzero.");

    share_report_a: assert property (@(posedge core_clk) disable iff (rst)
        rail_shutdown_report |-> $past(share_all_down))
        else $error("Shutdown reported before all devices down.");

    track_down_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && !follow_q[TRK_ALWAYS_BIT] && !power_good_flag
        |=> !track_ctrl.allow_down)
        else $error("Falling tracking allowed before power good.");
endmodule : rdsc_rail_config

// ### dv/rdsc_peer_rails.sv
// Model of the peer rails that send events over the inter-rail bus.
`timescale 1ns/1ns
module rdsc_peer_rails (
    input wire logic core_clk,
    output rdsc_pkg::rdsc_evt_t inter_rail_bus_rx
);
    import rdsc_pkg::*;
    initial begin
        inter_rail_bus_rx = '0;
    end
    // One event per call, valid for one cycle; fields are scrambled after.
    task automatic send(input rdsc_evt_kind_t k, input logic [4:0] id);
        @(posedge core_clk);
        inter_rail_bus_rx <= '{valid: 1'b1, kind: k, rail_identifier: id};
        @(posedge core_clk);
        inter_rail_bus_rx <= '{valid: 1'b0, kind: rdsc_evt_kind_t'(~k),
            rail_identifier: ~id};
    endtask : send
endmodule : rdsc_peer_rails

// ### dv/rdsc_rail_config_bench.sv
// Self-checking bench for the rail configuration bank.
`timescale 1ns/1ns
module rdsc_rail_config_bench;
    import rdsc_pkg::*;
    logic core_clk, rst, enable_request, power_good_flag, fault_spread_en;
    logic share_all_down, rail_output_on, rail_shutdown_report, un;
    logic [7:0] internal_temp, external_temp, off_delay_cycles, codes[6];
    logic [15:0] current_sense_gain;
    logic signed [7:0] adapt_hl_ns, adapt_lh_ns, nonoverlap_upper_bound;
    logic signed [9:0] hl_fet_nonoverlap_values_ns, lh_fet_nonoverlap_values_ns;
    logic signed [31:0] sense_element_resistance;
    logic [31:0] rd, wd, dflt[6], msk[6], mdl[6];
    rdsc_cmd_t cmd;
    rdsc_rsp_t rsp;
    rdsc_evt_t inter_rail_bus_rx, inter_rail_bus_tx;
    rdsc_track_t track_ctrl;
    int fails, checks_done;
    rdsc_rail_config #(.OFF_DLY_W(8)) dut (.core_clk(core_clk), .rst(rst),
        .ce(1'b1), .cmd(cmd), .rsp(rsp), .strap_order(16'h0000),
        .strap_rail_identifier(5'h02), .internal_temp(internal_temp),
        .external_temp(external_temp), .current_sense_gain(current_sense_gain),
        .sense_element_resistance(sense_element_resistance),
        .adapt_hl_ns(adapt_hl_ns), .adapt_lh_ns(adapt_lh_ns),
        .nonoverlap_upper_bound(nonoverlap_upper_bound),
        .hl_fet_nonoverlap_values_ns(hl_fet_nonoverlap_values_ns), .lh_fet_nonoverlap_values_ns(lh_fet_nonoverlap_values_ns),
        .enable_request(enable_request), .power_good_flag(power_good_flag),
        .fault_spread_en(fault_spread_en), .share_all_down(share_all_down),
        .off_delay_cycles(off_delay_cycles),
        .inter_rail_bus_rx(inter_rail_bus_rx),
        .inter_rail_bus_tx(inter_rail_bus_tx), .rail_output_on(rail_output_on),
        .rail_shutdown_report(rail_shutdown_report), .track_ctrl(track_ctrl));
    rdsc_peer_rails peer (.core_clk(core_clk),
        .inter_rail_bus_rx(inter_rail_bus_rx));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic close_out;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One command, held for one taking edge, then the answer is awaited.
    task automatic xfer(input logic wr, input logic [7:0] c, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        cmd <= '{valid: 1'b1, write: wr, code: c, wdata: d};
        @(posedge core_clk);
        cmd.valid <= 1'b0;
        for (n = 0; n < 4; n++) begin
            @(negedge core_clk);
            if (rsp.valid === 1'b1) break;
        end
        if (n == 4) begin
            fails++;
            close_out();
        end
        rd = rsp.rdata;
        un = rsp.unsupported;
    endtask : xfer
    task automatic wait_on(input logic exp, input int bound);
        int n;
        for (n = 0; n < bound; n++) begin
            @(negedge core_clk);
            if (rail_output_on === exp) break;
        end
        chk({31'h0, rail_output_on}, {31'h0, exp});
    endtask : wait_on
    task automatic hold_on(input logic exp, input int cyc);
        repeat (cyc) begin
            @(negedge core_clk);
            chk({31'h0, rail_output_on}, {31'h0, exp});
        end
    endtask : hold_on
    task automatic settle;
        repeat (4) @(negedge core_clk);
    endtask : settle
    initial begin
        codes = '{8'hDC, 8'hDD, 8'hDE, 8'hE0, 8'hE1, 8'hE2};
        dflt = '{32'h2C, 32'h1018, 32'h8686, 32'h0, 32'h0, 32'h0};
        msk = '{32'hFF, 32'hFFFF, 32'hFFFF, 32'h9F9F, 32'h87, 32'hFFFFFFFF};
        fails = 0;
        checks_done = 0;
        rst = 1'b1;
        cmd = '0;
        internal_temp = 8'd35;
        external_temp = 8'd75;
        current_sense_gain = 16'd10000;
        adapt_hl_ns = 8'sd30;
        adapt_lh_ns = 8'sd3;
        nonoverlap_upper_bound = 8'sd60;
        enable_request = 1'b0;
        power_good_flag = 1'b0;
        fault_spread_en = 1'b0;
        share_all_down = 1'b0;
        off_delay_cycles = 8'd4;
        void'($urandom(54234));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, codes[i], 32'h0);
            chk(rd, dflt[i]);
        end
        chk(hl_fet_nonoverlap_values_ns, 16);
        chk(lh_fet_nonoverlap_values_ns, 24);
        xfer(1'b1, 8'hE3, 32'h55);
        chk({31'h0, un}, 32'h1);
        $display("test reset_values done");
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 6; i++) begin
                wd = $urandom;
                if (i == 5) wd = wd & ~32'h4;
                xfer(1'b1, codes[i], wd);
                mdl[i] = wd & msk[i];
                xfer(1'b0, codes[i], 32'h0);
                chk(rd, mdl[i]);
            end
        end
        for (int i = 0; i < 6; i++) xfer(1'b1, codes[i], dflt[i]);
        $display("test register_access done");
        xfer(1'b1, 8'hDC, 32'h2C);
        settle();
        chk(sense_element_resistance, 10000 + 44 * 10);
        xfer(1'b1, 8'hDC, 32'hAC);
        settle();
        chk(sense_element_resistance, 10000 + 44 * 50);
        $display("test tempco done");
        nonoverlap_upper_bound <= 8'sd40;
        xfer(1'b1, 8'hDD, 32'h0530);
        settle();
        chk(hl_fet_nonoverlap_values_ns, 12);
        chk(lh_fet_nonoverlap_values_ns, 40);
        xfer(1'b1, 8'hDE, 32'h0606);
        settle();
        chk(hl_fet_nonoverlap_values_ns, 30);
        chk(lh_fet_nonoverlap_values_ns, 12);
        xfer(1'b1, 8'hDE, 32'h8686);
        adapt_hl_ns <= 8'sd50;
        settle();
        chk(hl_fet_nonoverlap_values_ns, 30);
        xfer(1'b1, 8'hDD, 32'h1018);
        settle();
        chk(hl_fet_nonoverlap_values_ns, 16);
        $display("test fet_nonoverlap_values done");
        xfer(1'b1, 8'hE1, 32'hFF);
        settle();
        chk(track_ctrl, 32'hF);
        xfer(1'b1, 8'hE1, 32'h82);
        settle();
        chk(track_ctrl, 32'hA);
        $display("test tracking done");
        xfer(1'b1, 8'hE0, 32'h8300);
        enable_request <= 1'b1;
        hold_on(1'b0, 6);
        peer.send(EVT_PWR_GOOD, 5'd3);
        wait_on(1'b1, 6);
        power_good_flag <= 1'b1;
        for (int n = 0; n < 6 && inter_rail_bus_tx.valid !== 1'b1; n++)
            @(negedge core_clk);
        chk(inter_rail_bus_tx, {1'b1, EVT_PWR_GOOD, 5'd2});
        xfer(1'b1, 8'hE0, 32'h8385);
        peer.send(EVT_PWR_DOWN, 5'd5);
        peer.send(EVT_PWR_DOWN, 5'd3);
        hold_on(1'b1, 3);
        wait_on(1'b0, 12);
        settle();
        chk(rail_shutdown_report, 0);
        share_all_down <= 1'b1;
        settle();
        chk(rail_shutdown_report, 1);
        $display("test sequencing done");
        xfer(1'b1, 8'hE0, 32'h0);
        enable_request <= 1'b0;
        settle();
        enable_request <= 1'b1;
        wait_on(1'b1, 12);
        xfer(1'b1, 8'hE2, 32'h0A);
        fault_spread_en <= 1'b1;
        peer.send(EVT_FAULT, 5'd4);
        hold_on(1'b1, 4);
        peer.send(EVT_FAULT, 5'd1);
        wait_on(1'b0, 3);
        peer.send(EVT_CLEAR, 5'd1);
        wait_on(1'b1, 12);
        fault_spread_en <= 1'b0;
        peer.send(EVT_FAULT, 5'd3);
        hold_on(1'b1, 6);
        peer.send(EVT_CLEAR, 5'd3);
        $display("test fault_spread done");
        close_out();
    end
endmodule : rdsc_rail_config_bench
